// *** shared/smcs_pkg.sv ***
// constants and types for the smart card session sequencer
package smcs_pkg;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int OSC_LOW_PERIOD_NS = 7812; // low-frequency oscillator period
   localparam int OSC_HIGH_PERIOD_NS = 390; // high-frequency period, T / 64
   localparam int LOW_TICK_CYC = OSC_LOW_PERIOD_NS / CLK_PERIOD_NS;
   localparam int HIGH_TICK_CYC = OSC_HIGH_PERIOD_NS / CLK_PERIOD_NS;
   localparam logic [10:0] POR_TICKS = 11'h400; // 1024 low periods
   localparam logic [10:0] WAKE_TICKS = 11'h180; // 384 low periods
   localparam logic [10:0] DEB_TICKS = 11'h280; // 640 low periods
   localparam logic [10:0] T_LINES = 11'h220; // 17T/2 high periods
   localparam logic [10:0] T_CLOCK = 11'h280; // between lines and reset
   localparam logic [10:0] T_RESET = 11'h2e0; // 23T/2 high periods
   localparam logic [10:0] DEA_RST = 11'h003; // 3T/64
   localparam logic [10:0] DEA_CLK = 11'h023; // + T/2
   localparam logic [10:0] DEA_IO = 11'h043; // + T
   localparam logic [10:0] DEA_VCC = 11'h063; // + 3T/2
   localparam logic [10:0] CNT_MAX = 11'h7ff;
   localparam logic [2:0] EXT_EDGES = 3'h4; // edges that prove an external clock
   localparam logic [3:0] DIV_SETTLE = 4'ha; // crystal periods before a new ratio
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [31:0] CFG_ADDR = 32'h0000_0000;
   localparam logic [31:0] STAT_ADDR = 32'h0000_0004;
   localparam logic [15:0] CFG_RESET = 16'h0808;
   localparam int CFG_TD_LSB = 0;
   localparam int CFG_PU_LSB = 8;
   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [2:0] {
      ST_POR, ST_SHUT, ST_DEEP, ST_WAKE, ST_RAMP, ST_RUN, ST_DEACT, ST_FALL
   } smcs_state_t;
   typedef enum logic [1:0] {IO_IDLE, IO_WAIT, IO_DRIVE, IO_PULL} smcs_io_t;
endpackage

// *** logic/smcs_sequencer.sv ***
// smart card session sequencer: power, clock, data line and status control
//
// Implementation choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
// Operation
// - after power-up fault status stays low until request high and presence low.
// - stay inactive in shutdown for 1024 low oscillator periods after supply rise; the wait is counted from reset or from the dip, not the rise.
// - any monitored supply below threshold runs a deactivation sequence.
// - on request fall, look for an external crystal clock; stop or start oscillator.
// - card clock is crystal divided by 8, 4, 2 or 1 from the selects.
// - ratio changes are synchronous with no short card clock pulse.
// - a running select change takes effect after 10 crystal periods.
// - divided card clock duty cycle stays between 45 and 55 percent.
// - first side to fall from idle is master; other side edge detect off.
// - after a delay drive master low onto slave, then pull-up pulse, then idle.
// - shutdown: contacts inactive, host lines released, supply off, low oscillator.
// - request high with both voltage selects low enters deep shutdown.
// - 384 low periods after request fall switch to high and ramp supply.
// - host lines high at t1+17T/2, card reset enabled at t1+23T/2.
// - card clock starts after lines go high and before reset enable.
// - on request rise: reset, clock, lines, supply off at fixed steps.
// - contacts are grounded when card supply is switched off; once card supply is low, return to low oscillator.
// - outside a session fault status shows presence; dips only reset internally.
// - session fault drives status low and deactivates; cleared by request rise.
// - insertion debounced 640 low periods; removal deactivates at first fall.
// - card reset follows the host reset input once enabled.
module smcs_sequencer #(
   parameter int LOW_TICK_CYC = smcs_pkg::LOW_TICK_CYC,
   parameter int HIGH_TICK_CYC = smcs_pkg::HIGH_TICK_CYC
) (
   input wire logic CORE_CLK,
   input wire logic RESETN,
   input wire logic CLK_EN,
   input wire logic ACTIVATION_REQUEST_N,
   input wire logic CARD_PRESENCE_IN,
   input wire logic DIVIDER_SELECT_A,
   input wire logic DIVIDER_SELECT_B,
   input wire logic LOW_SUPPLY_SELECT_N,
   input wire logic HIGH_SUPPLY_SELECT,
   input wire logic HOST_CARD_RESET_IN,
   input wire logic CRYSTAL_CLOCK_IN,
   input wire logic [2:0] SUPPLY_LOW,
   input wire logic OVERCURRENT,
   input wire logic OVERHEAT,
   input wire logic CARD_SUPPLY_LOW,
   input wire logic [2:0] HOST_LINE_IN,
   output logic [2:0] HOST_LINE_OUT,
   output logic [2:0] HOST_LINE_OE,
   input wire logic [2:0] CARD_LINE_IN,
   output logic [2:0] CARD_LINE_OUT,
   output logic [2:0] CARD_LINE_OE,
   output logic FAULT_STATUS_N,
   output logic CARD_CLOCK,
   output logic CARD_RESET,
   output logic CARD_SUPPLY_EN,
   output logic CARD_CONTACT_GROUND,
   output logic OSC_HIGH_MODE,
   output logic CRYSTAL_OSC_EN,
   output logic DEEP_SHUTDOWN,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP
);
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!RESETN);

   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   logic [19:0] raw, s1, s2;
   assign raw = {ACTIVATION_REQUEST_N, CARD_PRESENCE_IN, DIVIDER_SELECT_A, DIVIDER_SELECT_B,
      LOW_SUPPLY_SELECT_N, HIGH_SUPPLY_SELECT, HOST_CARD_RESET_IN, CRYSTAL_CLOCK_IN,
      HOST_LINE_IN, CARD_LINE_IN, SUPPLY_LOW, OVERCURRENT, OVERHEAT, CARD_SUPPLY_LOW};

   // every pin outside the bus port, reset and enable is foreign to CORE_CLK, so all pass two flops
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         s1 <= 20'h00000;
         s2 <= 20'h00000;
      end else if (CLK_EN) begin
         s1 <= raw;
         s2 <= s1;
      end
   end

   logic req, pres, sel_a, sel_b, vsel1, vsel2, hrst, xs, ovc, ovh, vcc_low;
   logic [2:0] h_in, c_in, sup;
   assign {req, pres, sel_a, sel_b, vsel1, vsel2, hrst, xs} = s2[19:12];
   assign {h_in, c_in, sup, ovc, ovh, vcc_low} = s2[11:0];

   // edge history resets like the synchroniser, so no false fall follows reset
   logic req_d, xs_d;
   logic [2:0] h_d, c_d;
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         req_d <= 1'b0;
         xs_d <= 1'b0;
         h_d <= 3'h0;
         c_d <= 3'h0;
      end else if (CLK_EN) begin
         req_d <= req;
         xs_d <= xs;
         h_d <= h_in;
         c_d <= c_in;
      end
   end
   logic req_fall, sup_low, x_rise, x_edge;
   assign req_fall = req_d & ~req;
   assign sup_low = |sup;
   assign x_edge = xs ^ xs_d;
   assign x_rise = xs & ~xs_d;

   // ----------------------------------------
   // internal oscillator ticks
   // ----------------------------------------
   smcs_pkg::smcs_state_t st, next_st;
   logic osc_high, lt, ht, tick;
   logic [15:0] lo_pre, hi_pre;
   assign lt = (lo_pre == 16'(LOW_TICK_CYC - 1));
   assign ht = (hi_pre == 16'(HIGH_TICK_CYC - 1));
   assign tick = osc_high ? ht : lt;

   // high divider only runs in high mode, so it starts fresh on each switch
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         lo_pre <= 16'h0000;
         hi_pre <= 16'h0000;
      end else if (CLK_EN) begin
         lo_pre <= lt ? 16'h0000 : lo_pre + 16'h0001;
         hi_pre <= (ht || !osc_high) ? 16'h0000 : hi_pre + 16'h0001;
      end
   end

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   logic [10:0] seq;
   logic fault_evt, abort, session;
   assign fault_evt = sup_low | ovc | ovh | ~pres;
   assign abort = req | fault_evt;
   assign session = (st == smcs_pkg::ST_RAMP) || (st == smcs_pkg::ST_RUN);

   always_comb begin
      next_st = st;
      unique case (st)
         smcs_pkg::ST_POR: if (seq == smcs_pkg::POR_TICKS) next_st = smcs_pkg::ST_SHUT;
         smcs_pkg::ST_SHUT: begin
            if (sup_low) next_st = smcs_pkg::ST_POR;
            else if (req_fall) next_st = smcs_pkg::ST_WAKE;
            else if (req && !vsel1 && !vsel2) next_st = smcs_pkg::ST_DEEP;
         end
         smcs_pkg::ST_DEEP: begin
            if (sup_low) next_st = smcs_pkg::ST_POR;
            else if (!req || vsel1 || vsel2) next_st = smcs_pkg::ST_SHUT;
         end
         smcs_pkg::ST_WAKE: begin
            if (req || sup_low) next_st = smcs_pkg::ST_SHUT;
            else if (seq == smcs_pkg::WAKE_TICKS) next_st = smcs_pkg::ST_RAMP;
         end
         smcs_pkg::ST_RAMP: begin
            if (abort) next_st = smcs_pkg::ST_DEACT;
            else if (seq == smcs_pkg::T_RESET) next_st = smcs_pkg::ST_RUN;
         end
         smcs_pkg::ST_RUN: if (abort) next_st = smcs_pkg::ST_DEACT;
         smcs_pkg::ST_DEACT: if (seq == smcs_pkg::DEA_VCC) next_st = smcs_pkg::ST_FALL;
         smcs_pkg::ST_FALL: if (vcc_low) next_st = smcs_pkg::ST_SHUT;
      endcase
   end

   // state and delay counter; the counter restarts on every state change
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         st <= smcs_pkg::ST_POR;
         seq <= 11'h000;
      end else if (CLK_EN) begin
         st <= next_st;
         if (next_st != st) seq <= 11'h000;
         else if (tick && seq != smcs_pkg::CNT_MAX) seq <= seq + 11'h001;
      end
   end

   // ----------------------------------------
   // sequence outputs
   // ----------------------------------------
   logic lines_up, clk_on, reset_en;
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         lines_up <= 1'b0;
         clk_on <= 1'b0;
         reset_en <= 1'b0;
      end else if (CLK_EN) begin
         if (st == smcs_pkg::ST_RAMP) begin
            if (seq >= smcs_pkg::T_LINES) lines_up <= 1'b1;
            if (seq >= smcs_pkg::T_CLOCK) clk_on <= 1'b1;
            if (seq >= smcs_pkg::T_RESET) reset_en <= 1'b1;
         end
         if (st == smcs_pkg::ST_DEACT) begin
            if (seq >= smcs_pkg::DEA_RST) reset_en <= 1'b0;
            if (seq >= smcs_pkg::DEA_CLK) clk_on <= 1'b0;
            if (seq >= smcs_pkg::DEA_IO) lines_up <= 1'b0;
         end
      end
   end

   // supply, oscillator mode and contact state follow the sequencer position
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         CARD_SUPPLY_EN <= 1'b0;
         osc_high <= 1'b0;
         DEEP_SHUTDOWN <= 1'b0;
         CARD_RESET <= 1'b0;
      end else if (CLK_EN) begin
         CARD_SUPPLY_EN <= session || (st == smcs_pkg::ST_DEACT && seq < smcs_pkg::DEA_VCC);
         osc_high <= session || st == smcs_pkg::ST_DEACT || st == smcs_pkg::ST_FALL;
         DEEP_SHUTDOWN <= (st == smcs_pkg::ST_DEEP);
         CARD_RESET <= reset_en & hrst;
      end
   end
   assign OSC_HIGH_MODE = osc_high;
   assign CARD_CONTACT_GROUND = ~CARD_SUPPLY_EN;

   // ----------------------------------------
   // clock source detection
   // ----------------------------------------
   logic [2:0] x_edges;
   logic ext_clk;
   assign ext_clk = (x_edges >= smcs_pkg::EXT_EDGES);
   // oscillator held off in the window so only a foreign clock can toggle the input
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         x_edges <= 3'h0;
         CRYSTAL_OSC_EN <= 1'b0;
      end else if (CLK_EN) begin
         if (st == smcs_pkg::ST_SHUT) x_edges <= 3'h0;
         else if (st == smcs_pkg::ST_WAKE && x_rise && !ext_clk) x_edges <= x_edges + 3'h1;
         if (st == smcs_pkg::ST_WAKE) CRYSTAL_OSC_EN <= 1'b0;
         else if (st == smcs_pkg::ST_RAMP) CRYSTAL_OSC_EN <= ~ext_clk;
         else if (st == smcs_pkg::ST_SHUT) CRYSTAL_OSC_EN <= 1'b0;
      end
   end

   // ----------------------------------------
   // card clock divider
   // ----------------------------------------
   logic [3:0] sel_ratio, ratio, hcnt, settle;
   logic div_ready;
   // value is crystal half-periods per card clock half-period
   always_comb begin
      unique case ({sel_a, sel_b})
         2'b00: sel_ratio = 4'h8;
         2'b01: sel_ratio = 4'h4;
         2'b11: sel_ratio = 4'h2;
         2'b10: sel_ratio = 4'h1;
      endcase
   end
   assign div_ready = (settle == smcs_pkg::DIV_SETTLE);

   // the selects must differ from the running ratio for ten crystal periods
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) settle <= 4'h0;
      else if (CLK_EN) begin
         if (sel_ratio == ratio) settle <= 4'h0;
         else if (x_rise && !div_ready) settle <= settle + 4'h1;
      end
   end

   // new ratio only at a toggle or while the clock is off, so every half period is whole
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         ratio <= 4'h8;
         hcnt <= 4'h0;
         CARD_CLOCK <= 1'b0;
      end else if (CLK_EN) begin
         if (!clk_on) begin
            CARD_CLOCK <= 1'b0;
            hcnt <= 4'h0;
            ratio <= sel_ratio;
         end else if (x_edge) begin
            if (hcnt + 4'h1 >= ratio) begin
               CARD_CLOCK <= ~CARD_CLOCK;
               hcnt <= 4'h0;
               if (div_ready) ratio <= sel_ratio;
            end else hcnt <= hcnt + 4'h1;
         end
      end
   end

   // ----------------------------------------
   // presence debounce and fault status
   // ----------------------------------------
   logic [10:0] deb;
   logic present, hold, flt;
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         deb <= 11'h000;
         present <= 1'b0;
      end else if (CLK_EN) begin
         if (!pres) begin
            deb <= 11'h000;
            present <= 1'b0;
         end else if (deb == smcs_pkg::DEB_TICKS) present <= 1'b1;
         else if (lt) deb <= deb + 11'h001;
      end
   end

   // fault latch: a fault only latches while request is low, so it never meets the request-driven clear
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         hold <= 1'b1;
         flt <= 1'b0;
         FAULT_STATUS_N <= 1'b0;
      end else if (CLK_EN) begin
         if (req && !pres) hold <= 1'b0;
         if (session && fault_evt && !req) flt <= 1'b1;
         else if (req && !session) flt <= 1'b0;
         if (hold) FAULT_STATUS_N <= 1'b0;
         else if (st == smcs_pkg::ST_DEEP) FAULT_STATUS_N <= pres;
         else FAULT_STATUS_N <= present & ~flt;
      end
   end

   // ----------------------------------------
   // data line bridges
   // ----------------------------------------
   logic [15:0] cfg;
   logic hold_low;
   assign hold_low = ~lines_up && (session || st == smcs_pkg::ST_DEACT);

   for (genvar i = 0; i < 3; i++) begin : g_line
      smcs_pkg::smcs_io_t io_st;
      logic master_card;
      logic [7:0] cnt;
      logic m_in, drv;
      assign m_in = master_card ? c_in[i] : h_in[i];
      assign drv = (io_st == smcs_pkg::IO_DRIVE) || (io_st == smcs_pkg::IO_PULL);
      // the slave edge detector is ignored until the line is idle again
      always_ff @(posedge CORE_CLK or negedge RESETN) begin
         if (!RESETN) begin
            io_st <= smcs_pkg::IO_IDLE;
            master_card <= 1'b0;
            cnt <= 8'h00;
         end else if (CLK_EN) begin
            if (!lines_up) io_st <= smcs_pkg::IO_IDLE;
            else begin
               unique case (io_st)
                  smcs_pkg::IO_IDLE: begin
                     cnt <= 8'h00;
                     if (h_d[i] && !h_in[i]) begin
                        master_card <= 1'b0;
                        io_st <= smcs_pkg::IO_WAIT;
                     end else if (c_d[i] && !c_in[i]) begin
                        master_card <= 1'b1;
                        io_st <= smcs_pkg::IO_WAIT;
                     end
                  end
                  smcs_pkg::IO_WAIT: begin
                     cnt <= cnt + 8'h01;
                     if (cnt == cfg[smcs_pkg::CFG_TD_LSB+:8]) io_st <= smcs_pkg::IO_DRIVE;
                  end
                  smcs_pkg::IO_DRIVE: begin
                     cnt <= 8'h00;
                     if (m_in) io_st <= smcs_pkg::IO_PULL;
                  end
                  smcs_pkg::IO_PULL: begin
                     cnt <= cnt + 8'h01;
                     if (cnt == cfg[smcs_pkg::CFG_PU_LSB+:8]) io_st <= smcs_pkg::IO_IDLE;
                  end
               endcase
            end
         end
      end
      // slave side carries the master level; before lines go up card lines are held low, host lines only in a session or deactivation
      assign HOST_LINE_OE[i] = lines_up ? (drv & master_card) : hold_low;
      assign HOST_LINE_OUT[i] = lines_up & (io_st == smcs_pkg::IO_PULL);
      assign CARD_LINE_OE[i] = lines_up ? (drv & ~master_card) : 1'b1;
      assign CARD_LINE_OUT[i] = lines_up & (io_st == smcs_pkg::IO_PULL);

      chk_io_drive: assert property (lines_up && io_st == smcs_pkg::IO_DRIVE |->
         (master_card ? HOST_LINE_OE[i] : CARD_LINE_OE[i]) && !HOST_LINE_OUT[i])
         else $error("slave side not driven low");
      chk_io_lock: assert property (io_st != smcs_pkg::IO_IDLE ##1 io_st != smcs_pkg::IO_IDLE
         |-> $stable(master_card))
         else $error("master side changed mid transfer");
   end

   // ----------------------------------------
   // bus slave
   // ----------------------------------------
   logic wr_pend;
   logic [31:0] wr_addr, stat;
   assign stat = {20'h00000, ext_clk, present, flt, clk_on, ratio, reset_en, st};
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;

   // write data arrives one cycle after its address phase
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         wr_pend <= 1'b0;
         wr_addr <= 32'h0000_0000;
         cfg <= smcs_pkg::CFG_RESET;
         HRDATA <= 32'h0000_0000;
      end else if (CLK_EN) begin
         if (wr_pend && wr_addr == smcs_pkg::CFG_ADDR) cfg <= HWDATA[15:0];
         if (HREADY) begin
            wr_pend <= HSEL & HTRANS[1] & HWRITE;
            wr_addr <= HADDR;
            if (HSEL && HTRANS[1] && !HWRITE) begin
               if (HADDR == smcs_pkg::CFG_ADDR) HRDATA <= {16'h0000, cfg};
               else if (HADDR == smcs_pkg::STAT_ADDR) HRDATA <= stat;
               else HRDATA <= 32'h0000_0000;
            end
         end
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   sequence s_deep_held;
      st == smcs_pkg::ST_DEEP ##1 st == smcs_pkg::ST_DEEP;
   endsequence
   sequence s_in_deact;
      st == smcs_pkg::ST_DEACT && seq > smcs_pkg::DEA_CLK;
   endsequence

   chk_por_quiet: assert property (st == smcs_pkg::ST_POR |-> !CARD_SUPPLY_EN ##1 !lines_up)
      else $error("activity during power-on wait");
   chk_hold_low: assert property (hold |=> !FAULT_STATUS_N)
      else $error("fault status high before release");
   chk_deep_mirror: assert property (s_deep_held |-> FAULT_STATUS_N == $past(pres) || hold)
      else $error("deep shutdown status not following presence");
   chk_ramp_start: assert property (st == smcs_pkg::ST_WAKE && next_st == smcs_pkg::ST_RAMP
      |-> ##2 CARD_SUPPLY_EN && osc_high)
      else $error("supply ramp and high mode not together");
   chk_clock_order: assert property ($rose(clk_on) |-> lines_up && !reset_en)
      else $error("card clock out of order");
   chk_deact_order: assert property (s_in_deact |=> !clk_on && !reset_en)
      else $error("reset or clock still on in deactivation");
   chk_extract: assert property (st == smcs_pkg::ST_RUN && !pres |=> st == smcs_pkg::ST_DEACT ##1 !present)
      else $error("removal did not deactivate");
   chk_div_glitch: assert property (clk_on && $past(clk_on) && ratio != $past(ratio)
      |-> CARD_CLOCK != $past(CARD_CLOCK))
      else $error("ratio changed between toggles");
endmodule

// *** tb/smcs_card_model.sv ***
// far-side model: external crystal clock, card supply decay and card line pull-ups
`timescale 1ns/1ps
module smcs_card_model (
   input wire logic clk,
   input wire logic supply_en,
   input wire logic xtal_run,
   input wire logic [2:0] line_out,
   input wire logic [2:0] line_oe,
   output logic xtal,
   output logic supply_low,
   output logic [2:0] line_in
);
   logic [4:0] fall_cnt = 5'h00;
   // clock runs from time zero unless removed, so it is present before any request falls
   initial begin
      xtal = 1'b0;
      forever #40 xtal = xtal_run ? ~xtal : 1'b0;
   end
   // a released card line sits at its pull-up level
   assign line_in = (line_oe & line_out) | ~line_oe;
   // supply needs 20 cycles to decay once switched off
   always @(posedge clk) begin
      if (supply_en) fall_cnt <= 5'h00;
      else if (fall_cnt != 5'h14) fall_cnt <= fall_cnt + 5'h01;
   end
   assign supply_low = (fall_cnt == 5'h14);
endmodule

// *** tb/test_smart_card_session_sequencer.sv ***
// self-checking bench for the session sequencer
`timescale 1ns/1ps
module test_smart_card_session_sequencer;
   logic clk = 0, rstn = 0, req_n = 1, pres = 0, sa = 0, sb = 0, lsel_n = 1, hsel_v = 1, hrst = 0, pull = 0;
   logic hsel = 0, hwr = 0, fsn, cclk, crst, csen, cgnd, oscm, xen, deep, xtal, cslow, hrdy;
   logic [1:0] htr = 2'h0;
   logic [31:0] ha = 32'h0, hwd = 32'h0, hrd, rd;
   logic [2:0] hli, hlo, hloe, cli, clo, cloe;
   int n_mismatch = 0, cmp_count = 0;
   logic [2:0] sup_v = 3'h0;
   logic ovc = 0, ovh = 0, xrun = 1;
   // host line 0 low when the device drives it low or the host pulls it
   assign hli = ~(hloe & ~hlo) & {2'b11, ~pull};
   smcs_sequencer #(.LOW_TICK_CYC(4), .HIGH_TICK_CYC(2)) dut (
      .CORE_CLK(clk), .RESETN(rstn), .CLK_EN(1'b1), .ACTIVATION_REQUEST_N(req_n), .CARD_PRESENCE_IN(pres),
      .DIVIDER_SELECT_A(sa), .DIVIDER_SELECT_B(sb), .LOW_SUPPLY_SELECT_N(lsel_n), .HIGH_SUPPLY_SELECT(hsel_v),
      .HOST_CARD_RESET_IN(hrst), .CRYSTAL_CLOCK_IN(xtal), .SUPPLY_LOW(sup_v), .OVERCURRENT(ovc), .OVERHEAT(ovh),
      .CARD_SUPPLY_LOW(cslow), .HOST_LINE_IN(hli), .HOST_LINE_OUT(hlo), .HOST_LINE_OE(hloe), .CARD_LINE_IN(cli),
      .CARD_LINE_OUT(clo), .CARD_LINE_OE(cloe), .FAULT_STATUS_N(fsn), .CARD_CLOCK(cclk), .CARD_RESET(crst),
      .CARD_SUPPLY_EN(csen), .CARD_CONTACT_GROUND(cgnd), .OSC_HIGH_MODE(oscm), .CRYSTAL_OSC_EN(xen),
      .DEEP_SHUTDOWN(deep), .HSEL(hsel), .HADDR(ha), .HTRANS(htr), .HWRITE(hwr), .HSIZE(3'h2), .HWDATA(hwd),
      .HREADY(hrdy), .HRDATA(hrd), .HREADYOUT(hrdy), .HRESP());
   smcs_card_model card (.clk(clk), .supply_en(csen), .xtal_run(xrun), .line_out(clo), .line_oe(cloe), .xtal(xtal),
      .supply_low(cslow), .line_in(cli));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function logic [3:0] ratio(input logic a, input logic b);
      return a ? (b ? 4'h2 : 4'h1) : (b ? 4'h4 : 4'h8);
   endfunction
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
         n_mismatch++;
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // one single transfer; the wait on ready is cut short only by the watchdog
   task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htr <= 2'h2;
      ha <= a;
      hwr <= w;
      @(posedge clk);
      while (hrdy !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htr <= 2'h0;
      hwd <= d;
      @(posedge clk);
      while (hrdy !== 1'b1) @(posedge clk);
      rd = hrd;
   endtask
   task wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // ----------------------------------------
   // clock, watchdog and scenarios
   // ----------------------------------------
   initial begin
      forever #5 clk = ~clk;
   end
   // the power-on wait, presence checks and three sessions need about 17300 cycles
   initial begin
      #300000;
      n_mismatch++;
      wrap_up();
   end
   initial begin
      void'($urandom(32'hbdcec6f1));
      cyc(2);
      rstn <= 1'b1;
      cyc(1);
      chk(32'(fsn), 32'h0);
      bus(1'b0, smcs_pkg::STAT_ADDR, 32'h0);
      chk(32'(rd[2:0]), 32'h0);
      bus(1'b1, smcs_pkg::CFG_ADDR, 32'h0a08);
      bus(1'b0, smcs_pkg::CFG_ADDR, 32'h0);
      chk(rd, 32'h0a08);
      bus(1'b0, 32'h10, 32'h0);
      chk(rd, 32'h0);
      cyc(4120);
      bus(1'b0, smcs_pkg::STAT_ADDR, 32'h0);
      chk(32'(rd[2:0]), 32'h1);
      chk(32'({csen, oscm, hloe}), 32'h0);
      $display("power-on wait done");
      pres <= 1'b1;
      cyc(2400);
      chk(32'(fsn), 32'h0);
      cyc(240);
      chk(32'(fsn), 32'h1);
      lsel_n <= 1'b0;
      hsel_v <= 1'b0;
      cyc(6);
      chk(32'({deep, fsn}), 32'h3);
      lsel_n <= 1'b1;
      hsel_v <= 1'b1;
      sa <= 1'($urandom);
      cyc(1);
      sb <= 1'($urandom);
      cyc(5);
      chk(32'(deep), 32'h0);
      bus(1'b0, smcs_pkg::STAT_ADDR, 32'h0);
      chk(32'(rd[7:4]), 32'(ratio(sa, sb)));
      $display("presence, deep shutdown and ratio done");
      req_n <= 1'b0;
      cyc(1500);
      chk(32'(oscm), 32'h0);
      cyc(80);
      chk(32'({oscm, csen}), 32'h3);
      cyc(1040);
      chk(32'(hli), 32'h0);
      cyc(90);
      chk(32'(hli), 32'h7);
      cyc(400);
      bus(1'b0, smcs_pkg::STAT_ADDR, 32'h0);
      chk(32'({rd[11], rd[8], rd[3], rd[2:0], xen}), 32'h7a);
      hrst <= 1'b1;
      cyc(6);
      chk(32'(crst), 32'h1);
      $display("activation done");
      pull <= 1'b1;
      cyc(14);
      chk(32'({cloe[0], clo[0]}), 32'h2);
      pull <= 1'b0;
      cyc(6);
      chk(32'({cloe[0], clo[0]}), 32'h3);
      cyc(34);
      chk(32'(cloe[0]), 32'h0);
      sa <= ~sa;
      cyc(20);
      bus(1'b0, smcs_pkg::STAT_ADDR, 32'h0);
      chk(32'(rd[7:4]), 32'(ratio(~sa, sb)));
      cyc(120);
      bus(1'b0, smcs_pkg::STAT_ADDR, 32'h0);
      chk(32'(rd[7:4]), 32'(ratio(sa, sb)));
      $display("data line and divider done");
      req_n <= 1'b1;
      cyc(20);
      chk(32'(crst), 32'h0);
      cyc(200);
      chk(32'(csen), 32'h0);
      cyc(40);
      chk(32'({oscm, cgnd}), 32'h1);
      $display("deactivation done");
      // second session: crystal removed, then a random supply, current or heat fault
      xrun <= 1'b0;
      req_n <= 1'b0;
      cyc(3110);
      chk(32'({xen, csen, fsn}), 32'h7);
      {sup_v, ovc, ovh} <= 5'($urandom_range(31, 1));
      cyc(6);
      chk(32'(fsn), 32'h0);
      {sup_v, ovc, ovh} <= 5'h00;
      cyc(400);
      chk(32'({csen, fsn}), 32'h0);
      req_n <= 1'b1;
      xrun <= 1'b1;
      cyc(6);
      chk(32'(fsn), 32'h1);
      $display("fault session done");
      // third session: card pulled while running
      req_n <= 1'b0;
      cyc(3110);
      pres <= 1'b0;
      cyc(6);
      bus(1'b0, smcs_pkg::STAT_ADDR, 32'h0);
      chk(32'({rd[2:0], fsn}), 32'hc);
      cyc(300);
      chk(32'({csen, cgnd}), 32'h1);
      $display("removal session done");
      wrap_up();
   end
endmodule
